// file: verilog/omf_pkg.sv
// Contract
// - or-literal ors W with the literal, result to W, updates N and Z.
// - or-register ors W with file register, result to destination, updates N and Z.
// - destination bit zero writes W, one writes back to the file register.
// - access bit zero resolves the file address within the access bank.
// - access bit one forms the address from bank select and file address.
// - extended set, access bit zero, address up to 5Fh uses indexed offset addressing.
// - pointer-load takes pointer select 0 to 2 and a 12-bit literal over two words.
// - pointer-load writes high nibble in first cycle, low byte in second.
// - move-register copies file register to destination, updates N and Z, one cycle.
// - move-register reaches any of the 256 bank addresses, bank chosen by access bit.
package omf_pkg;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } omf_phase_t;

    typedef enum logic [1:0] {
        M_EXEC = 2'b00,
        M_PTR2 = 2'b01,
        M_FLUSH = 2'b10
    } omf_mode_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ORL = 3'b001,
        OP_ORF = 3'b010,
        OP_MOV = 3'b011,
        OP_INC = 3'b100,
        OP_PTRH = 3'b101,
        OP_PTRL = 3'b110
    } omf_op_t;

    // opcode fields
    localparam logic [7:0] OMF_ENC_ORL = 8'h09;
    localparam logic [5:0] OMF_ENC_ORF = 6'h04;
    localparam logic [5:0] OMF_ENC_MOV = 6'h14;
    localparam logic [5:0] OMF_ENC_INCSZ = 6'h0f;
    localparam logic [5:0] OMF_ENC_INCSNZ = 6'h12;
    localparam logic [9:0] OMF_ENC_PTR = 10'h3b8;
    localparam logic [3:0] OMF_ENC_2W_MOVFF = 4'hc;
    localparam logic [5:0] OMF_ENC_2W_CTRL = 6'h3b;
    localparam logic [1:0] OMF_PTR_BAD_SEL = 2'h3;

    // addressing
    localparam logic [7:0] OMF_INDEX_LIMIT = 8'h5f;
    localparam logic [3:0] OMF_ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] OMF_ACCESS_HIGH_BANK = 4'hf;
    localparam int OMF_NUM_PTR = 3;
    localparam int OMF_INDEX_PTR = 2;

    // register map, byte addresses
    localparam logic [7:0] OMF_ADR_W = 8'h00;
    localparam logic [7:0] OMF_ADR_BANK = 8'h04;
    localparam logic [7:0] OMF_ADR_STATUS = 8'h08;
    localparam logic [7:0] OMF_ADR_CTRL = 8'h0c;
    localparam logic [7:0] OMF_ADR_PTR0 = 8'h10;
    localparam logic [7:0] OMF_ADR_PTR1 = 8'h14;
    localparam logic [7:0] OMF_ADR_PTR2 = 8'h18;
    localparam int OMF_STAT_Z = 0;
    localparam int OMF_STAT_N = 1;
    localparam int OMF_STAT_SKIP = 2;
    localparam int OMF_CTRL_EXT = 0;

    // reset values
    localparam logic [7:0] OMF_RST_W = 8'h00;
    localparam logic [3:0] OMF_RST_BANK = 4'h0;
    localparam logic [11:0] OMF_RST_PTR = 12'h000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } omf_wb_req_t;

    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } omf_dmem_t;

    typedef struct packed {
        omf_phase_t phase;
        omf_mode_t mode;
        omf_op_t op;
        logic d;
        logic skip;
        logic skip_sense;
        logic [1:0] sel;
        logic [7:0] lit;
        logic [7:0] opnd;
        logic [7:0] res;
        logic [7:0] w;
        logic [3:0] bank;
        logic neg;
        logic zero;
        logic ext_en;
        logic [OMF_NUM_PTR-1:0][11:0] ptr;
        logic instr_ack;
        omf_dmem_t dmem;
        logic wb_ack;
        logic [31:0] wb_dat;
    } omf_state_t;

endpackage

// file: verilog/omf_core.sv
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module omf_core
    import omf_pkg::*;
#(
    parameter int unsigned EXT_EN_RESET = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    output logic instr_ack_o,
    output omf_dmem_t dmem_o,
    input wire logic [7:0] dmem_rdata_i,
    input wire omf_wb_req_t wb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o
);

    if (EXT_EN_RESET > 1) begin : g_bad_ext_en
        $error("EXT_EN_RESET must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_two_word(input logic [15:0] word);
        is_two_word = (word[15:12] == OMF_ENC_2W_MOVFF) || (word[15:10] == OMF_ENC_2W_CTRL);
    endfunction

    function automatic logic [11:0] byte_addr(
        input logic [7:0] f,
        input logic a,
        input logic ext,
        input logic [3:0] bank,
        input logic [11:0] base
    );
        if (a) begin
            byte_addr = {bank, f};
        end else if (ext && f <= OMF_INDEX_LIMIT) begin
            byte_addr = 12'(base + {4'h0, f});
        end else if (f[7]) begin
            byte_addr = {OMF_ACCESS_HIGH_BANK, f};
        end else begin
            byte_addr = {OMF_ACCESS_LOW_BANK, f};
        end
    endfunction

    function automatic logic is_byte_op(input logic [15:0] word);
        is_byte_op = (word[15:10] == OMF_ENC_ORF) || (word[15:10] == OMF_ENC_MOV)
            || (word[15:10] == OMF_ENC_INCSZ) || (word[15:10] == OMF_ENC_INCSNZ);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    localparam omf_state_t RST_STATE = '{
        phase: PH_Q1,
        mode: M_EXEC,
        op: OP_NONE,
        d: 1'b0,
        skip: 1'b0,
        skip_sense: 1'b0,
        sel: 2'h0,
        lit: 8'h00,
        opnd: 8'h00,
        res: 8'h00,
        w: OMF_RST_W,
        bank: OMF_RST_BANK,
        neg: 1'b0,
        zero: 1'b0,
        ext_en: EXT_EN_RESET[0],
        ptr: {OMF_NUM_PTR{OMF_RST_PTR}},
        instr_ack: 1'b0,
        dmem: '0,
        wb_ack: 1'b0,
        wb_dat: 32'h0000_0000
    };

    omf_state_t q;
    omf_state_t n;

    always_comb begin
        n = q;
        n.instr_ack = 1'b0;
        unique case (q.phase)
            PH_Q1: begin
                // decode phase
                n.phase = PH_Q2;
                n.op = OP_NONE;
                n.dmem.rd = 1'b0;
                if (instr_valid_i) begin
                    n.instr_ack = 1'b1;
                    if (q.skip) begin
                        n.skip = 1'b0;
                        if (is_two_word(instr_i)) begin
                            n.mode = M_FLUSH;
                        end
                    end else if (q.mode == M_FLUSH) begin
                        n.mode = M_EXEC;
                    end else if (q.mode == M_PTR2) begin
                        n.op = OP_PTRL;
                        n.lit = instr_i[7:0];
                        n.mode = M_EXEC;
                    end else begin
                        n.d = instr_i[9];
                        n.lit = instr_i[7:0];
                        n.dmem.addr = byte_addr(instr_i[7:0], instr_i[8], q.ext_en, q.bank, q.ptr[OMF_INDEX_PTR]);
                        n.dmem.rd = is_byte_op(instr_i);
                        if (instr_i[15:8] == OMF_ENC_ORL) begin
                            n.op = OP_ORL;
                        end else if (instr_i[15:10] == OMF_ENC_ORF) begin
                            n.op = OP_ORF;
                        end else if (instr_i[15:10] == OMF_ENC_MOV) begin
                            n.op = OP_MOV;
                        end else if (instr_i[15:10] == OMF_ENC_INCSZ) begin
                            n.op = OP_INC;
                            n.skip_sense = 1'b0;
                        end else if (instr_i[15:10] == OMF_ENC_INCSNZ) begin
                            n.op = OP_INC;
                            n.skip_sense = 1'b1;
                        end else if (instr_i[15:6] == OMF_ENC_PTR && instr_i[5:4] != OMF_PTR_BAD_SEL) begin
                            n.op = OP_PTRH;
                            n.sel = instr_i[5:4];
                            n.lit = {4'h0, instr_i[3:0]};
                        end
                    end
                end
            end
            PH_Q2: begin
                // operand read
                n.phase = PH_Q3;
                n.dmem.rd = 1'b0;
                if (q.dmem.rd) begin
                    n.opnd = dmem_rdata_i;
                end
            end
            PH_Q3: begin
                // process
                n.phase = PH_Q4;
                unique case (q.op)
                    OP_ORL: n.res = q.w | q.lit;
                    OP_ORF: n.res = q.w | q.opnd;
                    OP_MOV: n.res = q.opnd;
                    OP_INC: n.res = 8'(q.opnd + 8'h01);
                    default: n.res = q.lit;
                endcase
                if ((q.op == OP_ORF || q.op == OP_MOV || q.op == OP_INC) && q.d) begin
                    n.dmem.wr = 1'b1;
                    n.dmem.wdata = n.res;
                end
            end
            PH_Q4: begin
                // destination write
                n.phase = PH_Q1;
                n.dmem.wr = 1'b0;
                unique case (q.op)
                    OP_ORL, OP_ORF, OP_MOV: begin
                        if (q.op == OP_ORL || !q.d) begin
                            n.w = q.res;
                        end
                        n.neg = q.res[7];
                        n.zero = (q.res == 8'h00);
                    end
                    OP_INC: begin
                        if (!q.d) begin
                            n.w = q.res;
                        end
                        n.skip = (q.res == 8'h00) ^ q.skip_sense;
                    end
                    OP_PTRH: begin
                        n.ptr[q.sel][11:8] = q.lit[3:0];
                        n.mode = M_PTR2;
                    end
                    OP_PTRL: begin
                        n.ptr[q.sel][7:0] = q.lit;
                    end
                    default: begin
                    end
                endcase
            end
        endcase

        // bus slave: ack one cycle after the request, write takes effect on the acked edge
        n.wb_ack = wb_i.cyc && wb_i.stb && !q.wb_ack;
        n.wb_dat = 32'h0000_0000;
        unique case (wb_i.adr)
            OMF_ADR_W: n.wb_dat = {24'h0, q.w};
            OMF_ADR_BANK: n.wb_dat = {28'h0, q.bank};
            OMF_ADR_STATUS: n.wb_dat = {29'h0, q.skip, q.neg, q.zero};
            OMF_ADR_CTRL: n.wb_dat = {31'h0, q.ext_en};
            OMF_ADR_PTR0: n.wb_dat = {20'h0, q.ptr[0]};
            OMF_ADR_PTR1: n.wb_dat = {20'h0, q.ptr[1]};
            OMF_ADR_PTR2: n.wb_dat = {20'h0, q.ptr[2]};
            default: n.wb_dat = 32'h0000_0000;
        endcase
        if (q.wb_ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0]) begin
            unique case (wb_i.adr)
                OMF_ADR_W: n.w = wb_i.dat[7:0];
                OMF_ADR_BANK: n.bank = wb_i.dat[3:0];
                OMF_ADR_CTRL: n.ext_en = wb_i.dat[OMF_CTRL_EXT];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= RST_STATE;
        end else if (ce_i) begin
            q <= n;
        end
    end

    assign instr_ack_o = q.instr_ack;
    assign dmem_o = q.dmem;
    assign wb_ack_o = q.wb_ack;
    assign wb_dat_o = q.wb_dat;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic byte_dec;
    assign byte_dec = ce_i && q.phase == PH_Q1 && instr_valid_i && !q.skip && q.mode == M_EXEC
        && (instr_i[15:10] == OMF_ENC_ORF || instr_i[15:10] == OMF_ENC_MOV);

    // a bus write to W overrides the core result at the same edge
    logic bus_wr_w;
    assign bus_wr_w = q.wb_ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0] && wb_i.adr == OMF_ADR_W;

    a_or_literal_w: assert property ((ce_i && q.phase == PH_Q3 && q.op == OP_ORL) ##1 ce_i
        |=> q.w == ($past(q.w, 2) | $past(q.lit, 2)))
        else $error("or-literal result not in W");

    a_flags_follow: assert property ((ce_i && q.phase == PH_Q4 && (q.op == OP_ORF || q.op == OP_MOV))
        |=> q.zero == ($past(q.res) == 8'h00) && q.neg == $past(q.res[7]))
        else $error("N or Z wrong after byte operation");

    a_dest_file: assert property ((q.phase == PH_Q4 && (q.op == OP_ORF || q.op == OP_MOV))
        |-> dmem_o.wr == q.d && (!q.d || dmem_o.wdata == q.res))
        else $error("destination write does not follow d");

    a_access_bank: assert property ((byte_dec && !instr_i[8] && !q.ext_en)
        |=> dmem_o.addr == {($past(instr_i[7]) ? OMF_ACCESS_HIGH_BANK : OMF_ACCESS_LOW_BANK), $past(instr_i[7:0])})
        else $error("access bank address wrong");

    a_bank_select: assert property ((byte_dec && instr_i[8])
        |=> dmem_o.addr == {$past(q.bank), $past(instr_i[7:0])} && dmem_o.rd)
        else $error("banked address wrong");

    a_indexed_mode: assert property ((byte_dec && !instr_i[8] && q.ext_en && instr_i[7:0] <= OMF_INDEX_LIMIT)
        |=> dmem_o.addr == 12'($past(q.ptr[2]) + {4'h0, $past(instr_i[7:0])}))
        else $error("indexed offset address wrong");

    a_ptr_bad_sel: assert property ((ce_i && q.phase == PH_Q1 && instr_valid_i && !q.skip && q.mode == M_EXEC
        && instr_i[15:6] == OMF_ENC_PTR && instr_i[5:4] == OMF_PTR_BAD_SEL) |=> q.op == OP_NONE)
        else $error("pointer select 3 accepted");

    a_ptr_high_first: assert property ((ce_i && q.phase == PH_Q4 && q.op == OP_PTRH)
        |=> q.mode == M_PTR2 && q.ptr[$past(q.sel)][11:8] == $past(q.lit[3:0]))
        else $error("pointer high nibble not loaded");

    a_mov_one_cycle: assert property ((ce_i && q.phase == PH_Q1 && q.op == OP_MOV)
        |-> q.res == q.opnd && q.zero == (q.opnd == 8'h00) && q.neg == q.opnd[7])
        else $error("move result or flags differ from operand");

    a_phase_strobes: assert property ((dmem_o.rd |-> q.phase == PH_Q2) and (dmem_o.wr |-> q.phase == PH_Q4))
        else $error("memory strobe outside its phase");

    a_skip_two_word: assert property ((ce_i && q.phase == PH_Q1 && instr_valid_i && q.skip
        && is_two_word(instr_i)) |=> q.mode == M_FLUSH && q.op == OP_NONE && !q.skip)
        else $error("skipped two-word instruction not flushed");

    a_ce_freeze: assert property (!ce_i |=> $stable(q))
        else $error("state moved while clock enable low");

    a_phase_wrap: assert property ((ce_i && q.phase == PH_Q4) |=> q.phase == PH_Q1)
        else $error("phase did not wrap to decode");

    a_ack_phase: assert property (instr_ack_o |-> q.phase == PH_Q2)
        else $error("instruction ack outside read phase");

    a_addr_hold: assert property ((ce_i && (q.phase == PH_Q2 || q.phase == PH_Q3)) |=> $stable(dmem_o.addr))
        else $error("memory address moved before write");

    a_literal_no_mem: assert property ((q.op == OP_ORL) |-> !dmem_o.rd && !dmem_o.wr)
        else $error("or-literal touched data memory");

    a_orl_flags: assert property ((ce_i && q.phase == PH_Q4 && q.op == OP_ORL)
        |=> q.zero == ($past(q.res) == 8'h00) && q.neg == $past(q.res[7]))
        else $error("N or Z wrong after or-literal");

    a_orf_result: assert property ((ce_i && q.phase == PH_Q3 && q.op == OP_ORF)
        |=> q.res == ($past(q.w) | $past(q.opnd)))
        else $error("or-register result wrong");

    a_file_keeps_w: assert property ((ce_i && q.phase == PH_Q4 && (q.op == OP_ORF || q.op == OP_MOV) && q.d
        && !bus_wr_w) |=> $stable(q.w))
        else $error("file destination changed W");

    a_access_above_index: assert property ((byte_dec && !instr_i[8] && q.ext_en
        && instr_i[7:0] > OMF_INDEX_LIMIT)
        |=> dmem_o.addr == {($past(instr_i[7]) ? OMF_ACCESS_HIGH_BANK : OMF_ACCESS_LOW_BANK), $past(instr_i[7:0])})
        else $error("access bank address wrong above index limit");

    a_ptr_accept: assert property ((ce_i && q.phase == PH_Q1 && instr_valid_i && !q.skip && q.mode == M_EXEC
        && instr_i[15:6] == OMF_ENC_PTR && instr_i[5:4] != OMF_PTR_BAD_SEL)
        |=> q.op == OP_PTRH && q.sel == $past(instr_i[5:4]) && q.lit[3:0] == $past(instr_i[3:0]))
        else $error("valid pointer select refused");

    a_ptr_second_word: assert property ((ce_i && q.phase == PH_Q1 && instr_valid_i && !q.skip
        && q.mode == M_PTR2)
        |=> q.op == OP_PTRL && q.mode == M_EXEC && q.lit == $past(instr_i[7:0]))
        else $error("pointer second word not taken as low byte");

    a_ptr_low_byte: assert property ((ce_i && q.phase == PH_Q4 && q.op == OP_PTRL)
        |=> q.ptr[$past(q.sel)][7:0] == $past(q.lit))
        else $error("pointer low byte not loaded");

    a_move_to_w: assert property ((ce_i && q.phase == PH_Q4 && q.op == OP_MOV && !q.d && !bus_wr_w)
        |=> q.w == $past(q.opnd))
        else $error("move did not copy register to W");

    a_skip_one_word: assert property ((ce_i && q.phase == PH_Q1 && instr_valid_i && q.skip
        && !is_two_word(instr_i)) |=> q.mode == M_EXEC && q.op == OP_NONE && !q.skip)
        else $error("skipped one-word instruction not discarded");

    a_flush_second: assert property ((ce_i && q.phase == PH_Q1 && instr_valid_i && q.mode == M_FLUSH)
        |=> q.mode == M_EXEC && q.op == OP_NONE)
        else $error("second word of skipped instruction executed");

endmodule

// file: test/omf_testbench.sv
`timescale 1ns/1ps
module testbench;
    import omf_pkg::*;
    logic clk_i;
    logic rst_i;
    logic ce_i;
    logic instr_valid_i;
    logic [15:0] instr_i;
    logic instr_ack_o;
    omf_dmem_t dmem_o;
    logic [7:0] dmem_rdata_i;
    omf_wb_req_t wb_i;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [1:0] ph_q;
    int n_mismatch;
    int num_checks;

    omf_core #(.EXT_EN_RESET(0)) dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .instr_valid_i(instr_valid_i),
        .instr_i(instr_i),
        .instr_ack_o(instr_ack_o),
        .dmem_o(dmem_o),
        .dmem_rdata_i(dmem_rdata_i),
        .wb_i(wb_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // bench copy of the four-phase counter, same reset point and enable as the core
    always @(posedge clk_i) begin
        ph_q <= rst_i ? 2'd0 : (ce_i ? ph_q + 2'd1 : ph_q);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // classic wishbone single cycle, ends at a falling edge
    task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        @(posedge clk_i);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_i <= '0;
        @(negedge clk_i);
        chk(wb_ack_o, 1'b0, "bus ack held");
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb_rw(1'b1, adr, dat, q);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_rw(1'b0, adr, 32'h0, q);
        chk(q, exp, "bus read");
    endtask

    // one instruction cycle: word in Q1, read in Q2, write in Q4
    task automatic exec(input logic [15:0] word, input logic [7:0] rdat, input logic e_rd,
                        input logic [11:0] e_adr, input logic e_wr, input logic [7:0] e_wdat);
        while (ph_q !== 2'd3) @(negedge clk_i);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= word;
        dmem_rdata_i <= rdat;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_i);
        chk(instr_ack_o, 1'b1, "instr ack");
        chk(dmem_o.rd, e_rd, "mem read strobe");
        if (e_rd) chk(dmem_o.addr, e_adr, "read address");
        @(posedge clk_i);
        dmem_rdata_i <= ~rdat;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(dmem_o.wr, e_wr, "mem write strobe");
        if (e_wr) chk(dmem_o.addr, e_adr, "write address");
        if (e_wr) chk(dmem_o.wdata, e_wdat, "write data");
    endtask

    function automatic logic [15:0] bo(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f);
        return {op, d, a, f};
    endfunction

    function automatic logic [15:0] pl1(input logic [1:0] s, input logic [11:0] k);
        return {OMF_ENC_PTR, s, k[11:8]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 4000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        logic [11:0] k;
        rst_i = 1'b1;
        ce_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = 16'h0000;
        dmem_rdata_i = 8'h00;
        wb_i = '0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        rd(OMF_ADR_W, 32'h0);
        rd(OMF_ADR_STATUS, 32'h0);
        rd(OMF_ADR_PTR2, 32'h0);
        rd(8'h20, 32'h0);
        // or literal, then zero result
        wr(OMF_ADR_W, 32'h9a);
        exec({OMF_ENC_ORL, 8'h35}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        rd(OMF_ADR_W, 32'hbf);
        rd(OMF_ADR_STATUS, 32'h02);
        wr(OMF_ADR_W, 32'h00);
        exec({OMF_ENC_ORL, 8'h00}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        rd(OMF_ADR_STATUS, 32'h01);
        // or register through bank select, both destinations
        wr(OMF_ADR_BANK, 32'h5);
        wr(OMF_ADR_W, 32'h91);
        exec(bo(OMF_ENC_ORF, 1'b0, 1'b1, 8'h13), 8'h13, 1'b1, 12'h513, 1'b0, 8'h0);
        rd(OMF_ADR_W, 32'h93);
        exec(bo(OMF_ENC_ORF, 1'b1, 1'b1, 8'h80), 8'h0c, 1'b1, 12'h580, 1'b1, 8'h9f);
        rd(OMF_ADR_W, 32'h93);
        rd(OMF_ADR_STATUS, 32'h02);
        // move register, access bank low and high halves
        exec(bo(OMF_ENC_MOV, 1'b0, 1'b0, 8'h22), 8'h22, 1'b1, 12'h022, 1'b0, 8'h0);
        rd(OMF_ADR_W, 32'h22);
        rd(OMF_ADR_STATUS, 32'h00);
        exec(bo(OMF_ENC_MOV, 1'b1, 1'b0, 8'hff), 8'h80, 1'b1, 12'hfff, 1'b1, 8'h80);
        rd(OMF_ADR_STATUS, 32'h02);
        exec(bo(OMF_ENC_MOV, 1'b0, 1'b1, 8'h00), 8'h00, 1'b1, 12'h500, 1'b0, 8'h0);
        rd(OMF_ADR_W, 32'h00);
        rd(OMF_ADR_STATUS, 32'h01);
        // pointer load into every pointer, then an ignored select
        for (int s = 0; s < 3; s++) begin
            k = 12'h3ab + 12'h111 * s[11:0];
            exec(pl1(s[1:0], k), 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
            exec({8'hf0, k[7:0]}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
            rd(OMF_ADR_PTR0 + 8'(4 * s), {20'h0, k});
        end
        exec(pl1(2'h3, 12'hfff), 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        exec({8'hf0, 8'hff}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        rd(OMF_ADR_PTR0, 32'h3ab);
        rd(OMF_ADR_PTR2, 32'h5cd);
        // indexed offset mode at and above its address limit
        wr(OMF_ADR_CTRL, 32'h1);
        exec(bo(OMF_ENC_MOV, 1'b0, 1'b0, 8'h5f), 8'h01, 1'b1, 12'h62c, 1'b0, 8'h0);
        exec(bo(OMF_ENC_MOV, 1'b0, 1'b0, 8'h60), 8'h01, 1'b1, 12'h060, 1'b0, 8'h0);
        exec(bo(OMF_ENC_MOV, 1'b0, 1'b1, 8'h10), 8'h01, 1'b1, 12'h510, 1'b0, 8'h0);
        wr(OMF_ADR_CTRL, 32'h0);
        exec(bo(OMF_ENC_MOV, 1'b0, 1'b0, 8'h5f), 8'h01, 1'b1, 12'h05f, 1'b0, 8'h0);
        // skip over a two-word pointer load: both words become idle cycles
        exec(bo(OMF_ENC_INCSZ, 1'b0, 1'b1, 8'h40), 8'hff, 1'b1, 12'h540, 1'b0, 8'h0);
        exec(pl1(2'h0, 12'h777), 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        exec({8'hf0, 8'h77}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        exec({OMF_ENC_ORL, 8'h11}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        rd(OMF_ADR_PTR0, 32'h3ab);
        rd(OMF_ADR_W, 32'h11);
        // no skip: the following word runs
        exec(bo(OMF_ENC_INCSZ, 1'b0, 1'b1, 8'h40), 8'h05, 1'b1, 12'h540, 1'b0, 8'h0);
        exec({OMF_ENC_ORL, 8'h01}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        rd(OMF_ADR_W, 32'h07);
        // clock enable low freezes the phase counter and all state
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        ce_i <= 1'b1;
        exec({OMF_ENC_ORL, 8'h08}, 8'h00, 1'b0, 12'h0, 1'b0, 8'h0);
        rd(OMF_ADR_W, 32'h0f);
        rd(OMF_ADR_STATUS, 32'h00);
        finish_test();
    end
endmodule
